// [verilog/smc_regs.vh]
/*
 * Register map, field positions, character codes and limits of the
 * short message command matcher.
 * Assumes a 32-bit AHB-Lite slave port; every register is one aligned word.
 */
`ifndef SMC_REGS_VH
`define SMC_REGS_VH

// ****************************************
// Register byte offsets and text group numbers
// ****************************************
`define SMC_REG_CTRL 12'h000
`define SMC_REG_PWD 12'h004
`define SMC_REG_LEN 12'h008
`define SMC_REG_STAT 12'h00C
`define SMC_ON_BASE 5'h02
`define SMC_OFF_BASE 5'h03
`define SMC_VAL_BASE 5'h04
`define SMC_SND_BASE 5'h05

// ****************************************
// Control fields and reset values
// ****************************************
`define SMC_CTRL_WORD 0
`define SMC_CTRL_PWD 1
`define SMC_CTRL_OFF 2
`define SMC_CTRL_SND 3
`define SMC_CTRL_RST 4'h0
`define SMC_PWD_RST 16'h0000
`define SMC_LEN_ON_LSB 0
`define SMC_LEN_OFF_LSB 8
`define SMC_LEN_VAL_LSB 16
`define SMC_LEN_SND_LSB 24

// ****************************************
// Characters and limits
// ****************************************
`define SMC_CH_DOT 16'h002E
`define SMC_CH_SP 16'h0020
`define SMC_CH_EQ 16'h003D
`define SMC_CH_MINUS 16'h002D
`define SMC_CH_PLUS 16'h002B
`define SMC_CH_STAR 16'h002A
`define SMC_CH_0 16'h0030
`define SMC_CH_9 16'h0039
`define SMC_CH_LO 16'h0020
`define SMC_CH_HI7 16'h007E
`define SMC_CH_XLO 16'h00C0
`define SMC_CH_XHI 16'h00FF
`define SMC_TXT_MAX 6'h20
`define SMC_SND_MAX 5'h1C
`define SMC_PWD_DIGITS 7'h04
`define SMC_MAX_CMDS 4'hA
`define SMC_MSG_MAX 8'hA0
`define SMC_VAL_POS_MAX 20'h07FFF
`define SMC_VAL_NEG_MAX 20'h08000

`endif

// [verilog/smc_command_matcher.v]
/*
 * Short message command matcher: parses the text of one received message,
 * checks password and sender, and drives one bit or one signed word output.
 * Assumes a receiver that pulses msg_start_i, then streams sender characters
 * (chr_sender_i high) and body characters, the last body one with chr_last_i.
 */
// Overview of operation
// - Bit mode: switch-on text found sets the bit output.
// - Bit mode: switch-off text found clears the bit output.
// - Reset input forces bit low over gate; gate low holds the bit.
// - Word mode: value text with valid value loads the word output.
// - Reset input clears word over gate; gate low holds the word.
// - Sender must match exactly; trailing star matches one or more characters, a lone star any sender.
// - Optional 4-digit code leads the message, followed by a dot.
// - With a sender configured, only matching senders change the output.
// - On and optional off text, or one value text, each up to 32 characters.
// - Values from -32768 to 32767, optional sign, after text and equals sign.
// - First non-blank character after equals sign not sign or digit makes command invalid.
// - At most ten commands per message are evaluated.
// - Split at dots, skip blanks beside dots, final dot optional.
// - Spaces or a dot after a value end it without error.
// - Only the first command for this block in a message acts.
// - Identical on and off texts switch the bit on.
// - Command texts hold only permitted seven-bit or accented codes.
// - Output changes only on an exact character match of a command text.
// - Bodies over 160 characters are dropped.
`timescale 1ns/1ps
`include "smc_regs.vh"

module smc_command_matcher #(
   parameter MSG_MAX = `SMC_MSG_MAX
) (
   input wire clk_sys_i,
   input wire nrst_i,
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   output wire [31:0] hrdata_o,
   output wire hreadyout_o,
   output wire hresp_o,
   input wire msg_start_i,
   input wire chr_valid_i,
   input wire [15:0] chr_data_i,
   input wire chr_sender_i,
   input wire chr_last_i,
   input wire gate_i,
   input wire clear_i,
   output wire bit_o,
   output wire [15:0] word_o,
   output wire msg_done_o
);

   // ****************************************
   // States
   // ****************************************
   localparam ST_IDLE = 4'b0001;
   localparam ST_RECV = 4'b0010;
   localparam ST_CLOSE = 4'b0100;
   localparam ST_APPLY = 4'b1000;
   localparam V_TXT = 3'd0, V_EQ = 3'd1, V_SGN = 3'd2, V_NEED = 3'd3, V_DIG = 3'd4, V_TRL = 3'd5, V_ERR = 3'd6;
   localparam A_ON = 2'd1, A_OFF = 2'd2, A_VAL = 2'd3;

   // ****************************************
   // Bus slave
   // ****************************************
   reg [3:0] ctrl_ff;
   reg [15:0] pwd_ff;
   reg [5:0] on_len_ff, off_len_ff, val_len_ff;
   reg [4:0] snd_len_ff;
   reg [15:0] on_mem [0:31];
   reg [15:0] off_mem [0:31];
   reg [15:0] val_mem [0:31];
   reg [15:0] snd_mem [0:31];
   reg wr_ff;
   reg [11:0] waddr_ff;
   reg [31:0] hrdata_ff;
   reg hready_ff;
   reg bit_ff, done_ff, last_ok_ff;
   reg [15:0] word_ff;
   reg [3:0] st_ff, nxt_st;
   reg [31:0] rd_val;
   wire take = hsel_i && htrans_i[1] && hready_i;
   wire [4:0] widx = waddr_ff[6:2];
   wire [4:0] wgrp = waddr_ff[11:7];
   wire [15:0] wchr = hwdata_i[15:0];
   wire chr_ok = (wchr >= `SMC_CH_LO && wchr <= `SMC_CH_HI7) || (wchr >= `SMC_CH_XLO && wchr <= `SMC_CH_XHI);

   function [5:0] clamp6;
      input [5:0] v;
      begin
         clamp6 = (v > `SMC_TXT_MAX) ? `SMC_TXT_MAX : v;
      end
   endfunction

   always @* begin
      rd_val = 32'h0000_0000;
      case (haddr_i[11:7])
         5'h00: begin
            case (haddr_i[11:0])
               `SMC_REG_CTRL: rd_val = {28'h0000000, ctrl_ff};
               `SMC_REG_PWD: rd_val = {16'h0000, pwd_ff};
               `SMC_REG_LEN: rd_val = {3'h0, snd_len_ff, 2'h0, val_len_ff, 2'h0, off_len_ff, 2'h0, on_len_ff};
               `SMC_REG_STAT: rd_val = {word_ff, 13'h0000, st_ff != ST_IDLE, last_ok_ff, bit_ff};
               default: rd_val = 32'h0000_0000;
            endcase
         end
         `SMC_ON_BASE: rd_val = {16'h0000, on_mem[haddr_i[6:2]]};
         `SMC_OFF_BASE: rd_val = {16'h0000, off_mem[haddr_i[6:2]]};
         `SMC_VAL_BASE: rd_val = {16'h0000, val_mem[haddr_i[6:2]]};
         `SMC_SND_BASE: rd_val = {16'h0000, snd_mem[haddr_i[6:2]]};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ff <= 1'b0;
         waddr_ff <= 12'h000;
         hrdata_ff <= 32'h0000_0000;
         hready_ff <= 1'b1;
         ctrl_ff <= `SMC_CTRL_RST;
         pwd_ff <= `SMC_PWD_RST;
         on_len_ff <= 6'h00;
         off_len_ff <= 6'h00;
         val_len_ff <= 6'h00;
         snd_len_ff <= 5'h00;
      end else begin
         hready_ff <= 1'b1;
         wr_ff <= take && hwrite_i;
         waddr_ff <= haddr_i[11:0];
         if (take && !hwrite_i) begin
            hrdata_ff <= rd_val;
         end
         if (wr_ff && waddr_ff == `SMC_REG_CTRL) begin
            ctrl_ff <= hwdata_i[3:0];
         end
         if (wr_ff && waddr_ff == `SMC_REG_PWD) begin
            pwd_ff <= hwdata_i[15:0];
         end
         if (wr_ff && waddr_ff == `SMC_REG_LEN) begin
            on_len_ff <= clamp6(hwdata_i[`SMC_LEN_ON_LSB +: 6]);
            off_len_ff <= clamp6(hwdata_i[`SMC_LEN_OFF_LSB +: 6]);
            val_len_ff <= clamp6(hwdata_i[`SMC_LEN_VAL_LSB +: 6]);
            snd_len_ff <= (hwdata_i[`SMC_LEN_SND_LSB +: 5] > `SMC_SND_MAX) ? `SMC_SND_MAX
               : hwdata_i[`SMC_LEN_SND_LSB +: 5];
         end
      end
   end

   // Text stores carry no reset; software loads them before enabling use
   always @(posedge clk_sys_i) begin
      if (wr_ff && chr_ok) begin
         if (wgrp == `SMC_ON_BASE) on_mem[widx] <= wchr;
         if (wgrp == `SMC_OFF_BASE) off_mem[widx] <= wchr;
         if (wgrp == `SMC_VAL_BASE) val_mem[widx] <= wchr;
      end
      if (wr_ff && wgrp == `SMC_SND_BASE) begin
         snd_mem[widx] <= wchr;
      end
   end

   assign hrdata_o = hrdata_ff;
   assign hreadyout_o = hready_ff;
   assign hresp_o = 1'b0;

   // ****************************************
   // Message parser
   // ****************************************
   reg [6:0] pos_ff, nxt_pos;
   reg seg_act_ff, nxt_seg_act;
   reg on_ok_ff, nxt_on_ok, off_ok_ff, nxt_off_ok, pwd_run_ff, nxt_pwd_run;
   reg [2:0] vph_ff, nxt_vph;
   reg vneg_ff, nxt_vneg;
   reg [16:0] vmag_ff, nxt_vmag;
   reg [3:0] cmd_cnt_ff, nxt_cmd_cnt;
   reg pwd_done_ff, nxt_pwd_done, pwd_ok_ff, nxt_pwd_ok;
   reg act_vld_ff, nxt_act_vld;
   reg [1:0] act_kind_ff, nxt_act_kind;
   reg [15:0] act_val_ff, nxt_act_val;
   reg [4:0] snd_idx_ff, nxt_snd_idx;
   reg snd_ok_ff, nxt_snd_ok, snd_wild_ff, nxt_snd_wild;
   reg [7:0] body_cnt_ff, nxt_body_cnt;
   reg too_long_ff, nxt_too_long;
   reg seg_close, seg_last, msg_clr;
   reg [19:0] acc;
   wire [15:0] c = chr_data_i;
   wire is_dig = c >= `SMC_CH_0 && c <= `SMC_CH_9;
   wire in_pwd = ctrl_ff[`SMC_CTRL_PWD] && !pwd_done_ff;
   wire [4:0] pi = pos_ff[4:0];
   wire [3:0] pdig = pwd_ff[15 - 4 * pi[1:0] -: 4];
   wire star_alone = snd_len_ff == 5'h01 && snd_mem[0] == `SMC_CH_STAR;
   wire snd_good = !ctrl_ff[`SMC_CTRL_SND] ||
      (snd_ok_ff && (snd_wild_ff || snd_idx_ff == snd_len_ff || star_alone));
   wire pwd_good = !ctrl_ff[`SMC_CTRL_PWD] || pwd_ok_ff;
   wire msg_ok = pwd_good && snd_good && !too_long_ff && act_vld_ff;

   always @* begin
      nxt_st = st_ff;
      nxt_pos = pos_ff;
      nxt_seg_act = seg_act_ff;
      nxt_on_ok = on_ok_ff;
      nxt_off_ok = off_ok_ff;
      nxt_pwd_run = pwd_run_ff;
      nxt_vph = vph_ff;
      nxt_vneg = vneg_ff;
      nxt_vmag = vmag_ff;
      nxt_cmd_cnt = cmd_cnt_ff;
      nxt_pwd_done = pwd_done_ff;
      nxt_pwd_ok = pwd_ok_ff;
      nxt_act_vld = act_vld_ff;
      nxt_act_kind = act_kind_ff;
      nxt_act_val = act_val_ff;
      nxt_snd_idx = snd_idx_ff;
      nxt_snd_ok = snd_ok_ff;
      nxt_snd_wild = snd_wild_ff;
      nxt_body_cnt = body_cnt_ff;
      nxt_too_long = too_long_ff;
      seg_close = 1'b0;
      seg_last = 1'b0;
      msg_clr = 1'b0;
      acc = {3'h0, vmag_ff} * 20'd10 + {16'h0000, c[3:0]};
      case (st_ff)
         ST_IDLE: begin
            if (msg_start_i) begin
               nxt_st = ST_RECV;
               msg_clr = 1'b1;
            end
         end
         ST_RECV: begin
            if (chr_valid_i && chr_sender_i) begin
               if (snd_idx_ff != 5'h1F) nxt_snd_idx = snd_idx_ff + 5'h01;
               if (!snd_wild_ff) begin
                  if (snd_idx_ff >= snd_len_ff) begin
                     nxt_snd_ok = 1'b0;
                  end else if (snd_mem[snd_idx_ff] == `SMC_CH_STAR && snd_idx_ff == snd_len_ff - 5'h01) begin
                     nxt_snd_wild = 1'b1;
                  end else if (snd_mem[snd_idx_ff] != c) begin
                     nxt_snd_ok = 1'b0;
                  end
               end
            end else if (chr_valid_i) begin
               if (body_cnt_ff == MSG_MAX) nxt_too_long = 1'b1;
               else nxt_body_cnt = body_cnt_ff + 8'h01;
               if (chr_last_i) nxt_st = ST_CLOSE;
               if (c == `SMC_CH_DOT) begin
                  seg_close = 1'b1;
               end else if (seg_act_ff || c != `SMC_CH_SP) begin
                  nxt_seg_act = 1'b1;
                  if (pos_ff != 7'h7F) nxt_pos = pos_ff + 7'h01;
                  if (in_pwd) begin
                     if (pos_ff < `SMC_PWD_DIGITS) begin
                        if (!is_dig || c[3:0] != pdig) nxt_pwd_run = 1'b0;
                     end else if (c != `SMC_CH_SP) begin
                        nxt_pwd_run = 1'b0;
                     end
                  end else begin
                     // Past the text length only blanks may follow, so a longer word never matches
                     if (pos_ff < {1'b0, on_len_ff}) begin
                        if (c != on_mem[pi]) nxt_on_ok = 1'b0;
                     end else if (c != `SMC_CH_SP) nxt_on_ok = 1'b0;
                     if (pos_ff < {1'b0, off_len_ff}) begin
                        if (c != off_mem[pi]) nxt_off_ok = 1'b0;
                     end else if (c != `SMC_CH_SP) nxt_off_ok = 1'b0;
                     case (vph_ff)
                        V_TXT: begin
                           if (val_len_ff == 6'h00 || c != val_mem[pi]) nxt_vph = V_ERR;
                           else if (pos_ff + 7'h01 == {1'b0, val_len_ff}) nxt_vph = V_EQ;
                        end
                        V_EQ: begin
                           if (c == `SMC_CH_EQ) nxt_vph = V_SGN;
                           else if (c != `SMC_CH_SP) nxt_vph = V_ERR;
                        end
                        V_SGN: begin
                           if (c == `SMC_CH_MINUS) begin
                              nxt_vneg = 1'b1;
                              nxt_vph = V_NEED;
                           end else if (c == `SMC_CH_PLUS) nxt_vph = V_NEED;
                           else if (is_dig) begin
                              nxt_vmag = {13'h0000, c[3:0]};
                              nxt_vph = V_DIG;
                           end else if (c != `SMC_CH_SP) nxt_vph = V_ERR;
                        end
                        V_NEED, V_DIG: begin
                           if (is_dig) begin
                              nxt_vmag = acc[16:0];
                              nxt_vph = V_DIG;
                              if (acc > (vneg_ff ? `SMC_VAL_NEG_MAX : `SMC_VAL_POS_MAX)) nxt_vph = V_ERR;
                           end else if (c == `SMC_CH_SP && vph_ff == V_DIG) nxt_vph = V_TRL;
                           else nxt_vph = V_ERR;
                        end
                        V_TRL: begin
                           if (c != `SMC_CH_SP) nxt_vph = V_ERR;
                        end
                        default: nxt_vph = V_ERR;
                     endcase
                  end
               end
            end
         end
         ST_CLOSE: begin
            seg_close = 1'b1;
            seg_last = 1'b1;
            nxt_st = ST_APPLY;
         end
         ST_APPLY: begin
            nxt_st = ST_IDLE;
         end
         default: nxt_st = ST_IDLE;
      endcase
      if (seg_close) begin
         if (in_pwd) begin
            nxt_pwd_done = 1'b1;
            nxt_pwd_ok = pwd_run_ff && pos_ff >= `SMC_PWD_DIGITS && !seg_last;
         end else if (seg_act_ff && cmd_cnt_ff != `SMC_MAX_CMDS) begin
            nxt_cmd_cnt = cmd_cnt_ff + 4'h1;
            if (!act_vld_ff) begin
               if (!ctrl_ff[`SMC_CTRL_WORD]) begin
                  // On is tested first so identical texts switch on
                  if (on_ok_ff && on_len_ff != 6'h00 && pos_ff >= {1'b0, on_len_ff}) begin
                     nxt_act_vld = 1'b1;
                     nxt_act_kind = A_ON;
                  end else if (ctrl_ff[`SMC_CTRL_OFF] && off_ok_ff && off_len_ff != 6'h00
                     && pos_ff >= {1'b0, off_len_ff}) begin
                     nxt_act_vld = 1'b1;
                     nxt_act_kind = A_OFF;
                  end
               end else if (vph_ff == V_DIG || vph_ff == V_TRL) begin
                  nxt_act_vld = 1'b1;
                  nxt_act_kind = A_VAL;
                  nxt_act_val = vneg_ff ? 16'h0000 - vmag_ff[15:0] : vmag_ff[15:0];
               end
            end
         end
      end
      if (seg_close || msg_clr) begin
         nxt_pos = 7'h00;
         nxt_seg_act = 1'b0;
         nxt_on_ok = 1'b1;
         nxt_off_ok = 1'b1;
         nxt_pwd_run = 1'b1;
         nxt_vph = V_TXT;
         nxt_vneg = 1'b0;
         nxt_vmag = 17'h00000;
      end
      if (msg_clr) begin
         nxt_cmd_cnt = 4'h0;
         nxt_pwd_done = 1'b0;
         nxt_pwd_ok = 1'b0;
         nxt_act_vld = 1'b0;
         nxt_act_kind = 2'd0;
         nxt_snd_idx = 5'h00;
         nxt_snd_ok = 1'b1;
         nxt_snd_wild = 1'b0;
         nxt_body_cnt = 8'h00;
         nxt_too_long = 1'b0;
      end
   end

   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff <= ST_IDLE;
         pos_ff <= 7'h00;
         seg_act_ff <= 1'b0;
         on_ok_ff <= 1'b1;
         off_ok_ff <= 1'b1;
         pwd_run_ff <= 1'b1;
         vph_ff <= V_TXT;
         vneg_ff <= 1'b0;
         vmag_ff <= 17'h00000;
         cmd_cnt_ff <= 4'h0;
         pwd_done_ff <= 1'b0;
         pwd_ok_ff <= 1'b0;
         act_vld_ff <= 1'b0;
         act_kind_ff <= 2'd0;
         act_val_ff <= 16'h0000;
         snd_idx_ff <= 5'h00;
         snd_ok_ff <= 1'b1;
         snd_wild_ff <= 1'b0;
         body_cnt_ff <= 8'h00;
         too_long_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         pos_ff <= nxt_pos;
         seg_act_ff <= nxt_seg_act;
         on_ok_ff <= nxt_on_ok;
         off_ok_ff <= nxt_off_ok;
         pwd_run_ff <= nxt_pwd_run;
         vph_ff <= nxt_vph;
         vneg_ff <= nxt_vneg;
         vmag_ff <= nxt_vmag;
         cmd_cnt_ff <= nxt_cmd_cnt;
         pwd_done_ff <= nxt_pwd_done;
         pwd_ok_ff <= nxt_pwd_ok;
         act_vld_ff <= nxt_act_vld;
         act_kind_ff <= nxt_act_kind;
         act_val_ff <= nxt_act_val;
         snd_idx_ff <= nxt_snd_idx;
         snd_ok_ff <= nxt_snd_ok;
         snd_wild_ff <= nxt_snd_wild;
         body_cnt_ff <= nxt_body_cnt;
         too_long_ff <= nxt_too_long;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   wire apply = st_ff == ST_APPLY && msg_ok && gate_i;

   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bit_ff <= 1'b0;
         word_ff <= 16'h0000;
         done_ff <= 1'b0;
         last_ok_ff <= 1'b0;
      end else begin
         done_ff <= st_ff == ST_APPLY;
         if (st_ff == ST_APPLY) last_ok_ff <= msg_ok;
         if (clear_i) begin
            bit_ff <= 1'b0;
            word_ff <= 16'h0000;
         end else if (apply) begin
            if (act_kind_ff == A_ON) bit_ff <= 1'b1;
            if (act_kind_ff == A_OFF) bit_ff <= 1'b0;
            if (act_kind_ff == A_VAL) word_ff <= act_val_ff;
         end
      end
   end

   assign bit_o = bit_ff;
   assign word_o = word_ff;
   assign msg_done_o = done_ff;

endmodule

// [tb/smc_checker_assertions.sv]
/*
 * Port-level checker for the short message command matcher.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
// ****************************************
// Checker
// ****************************************
module smc_checker (
   input wire clk_sys_i,
   input wire nrst_i,
   input wire chr_valid_i,
   input wire chr_last_i,
   input wire gate_i,
   input wire clear_i,
   input wire bit_o,
   input wire [15:0] word_o,
   input wire msg_done_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);
   // Clear wins over gate and over a pending apply
   AST_CLR_BIT: assert property (clear_i |=> !bit_o)
      else $error("bit output not cleared");
   AST_HOLD_BIT: assert property (!gate_i && !clear_i |=> $stable(bit_o))
      else $error("bit output moved with gate low");
   AST_CLR_WORD: assert property (clear_i |=> word_o == 16'h0000)
      else $error("word output not cleared");
   AST_HOLD_WORD: assert property (!gate_i && !clear_i |=> $stable(word_o))
      else $error("word output moved with gate low");
   AST_BIT_AT_DONE: assert property ($changed(bit_o) && !$past(clear_i) |-> msg_done_o)
      else $error("bit output changed outside message end");
   AST_WORD_AT_DONE: assert property ($changed(word_o) && !$past(clear_i) |-> msg_done_o)
      else $error("word output changed outside message end");
   AST_DONE_PULSE: assert property (msg_done_o |=> !msg_done_o)
      else $error("message end flag longer than one cycle");
   AST_DONE_LAT: assert property (chr_valid_i && chr_last_i |-> ##3 msg_done_o)
      else $error("message end flag late");
endmodule

bind smc_command_matcher smc_checker u_chk (
   .clk_sys_i(clk_sys_i),
   .nrst_i(nrst_i),
   .chr_valid_i(chr_valid_i),
   .chr_last_i(chr_last_i),
   .gate_i(gate_i),
   .clear_i(clear_i),
   .bit_o(bit_o),
   .word_o(word_o),
   .msg_done_o(msg_done_o)
);

// [tb/smc_sender_model.sv]
/*
 * Modem-side receiver model: streams sender number and message body.
 * Assumes send is called right after a rising edge with the block idle.
 */
`timescale 1ns/1ps
// ****************************************
// Receiver model
// ****************************************
module smc_sender_model (
   input wire clk_sys_i,
   output logic msg_start_o,
   output logic chr_valid_o,
   output logic [15:0] chr_data_o,
   output logic chr_sender_o,
   output logic chr_last_o
);
   initial begin
      msg_start_o = 0;
      chr_valid_o = 0;
      chr_data_o = 16'h5A5A;
      chr_sender_o = 0;
      chr_last_o = 0;
   end
   task automatic put(input logic [15:0] c, input logic s, input logic l);
      chr_valid_o <= 1;
      chr_data_o <= c;
      chr_sender_o <= s;
      chr_last_o <= l;
      @(posedge clk_sys_i);
   endtask
   // Caller keeps to ten commands unless a scenario exceeds it on purpose
   task automatic send(input string snd, input string body);
      msg_start_o <= 1;
      @(posedge clk_sys_i);
      msg_start_o <= 0;
      for (int i = 0; i < snd.len(); i++) put({8'h00, snd[i]}, 1'b1, 1'b0);
      for (int i = 0; i < body.len(); i++) put({8'h00, body[i]}, 1'b0, i == body.len() - 1);
      chr_valid_o <= 0;
      chr_sender_o <= 0;
      chr_last_o <= 0;
      // Idle data toggles so a stale character never looks valid
      chr_data_o <= ~chr_data_o;
   endtask
endmodule

// [tb/sms_command_matcher_bench.sv]
/*
 * Self-checking bench of the short message command matcher.
 * Assumes zero-wait AHB-Lite slave and the receiver model in smc_sender_model.
 */
`timescale 1ns/1ps
`include "smc_regs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
$display("mismatch %s expected %0h seen %0h", n, e, g); end end
// ****************************************
// Bench
// ****************************************
module sms_command_matcher_bench;
   logic clk_sys_i = 0, nrst_i = 0, hsel_i = 0, hwrite_i = 0, gate_i = 1, clear_i = 0;
   logic [31:0] haddr_i = 0, hwdata_i = 0, rd;
   logic [1:0] htrans_i = 0;
   wire [31:0] hrdata_o;
   wire [15:0] word_o, chr_data_i;
   wire hreadyout_o, hresp_o, bit_o, msg_done_o, msg_start_i, chr_valid_i, chr_sender_i, chr_last_i;
   int num_errors = 0, samples_checked = 0;
   string snd = "123";
   always #2 clk_sys_i = ~clk_sys_i;
   smc_command_matcher u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .msg_start_i(msg_start_i),
      .chr_valid_i(chr_valid_i), .chr_data_i(chr_data_i), .chr_sender_i(chr_sender_i),
      .chr_last_i(chr_last_i), .gate_i(gate_i), .clear_i(clear_i), .bit_o(bit_o), .word_o(word_o),
      .msg_done_o(msg_done_o));
   smc_sender_model u_snd (.clk_sys_i(clk_sys_i), .msg_start_o(msg_start_i), .chr_valid_o(chr_valid_i),
      .chr_data_o(chr_data_i), .chr_sender_o(chr_sender_i), .chr_last_o(chr_last_i));
   task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      hsel_i <= 1;
      haddr_i <= {20'h0, a};
      hwrite_i <= w;
      htrans_i <= 2'h2;
      do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
      // Select stays up with IDLE on htrans so a following call never reassigns it in the same step
      rd = hrdata_o;
   endtask
   task txt(input logic [4:0] base, input string s);
      for (int i = 0; i < s.len(); i++) xfer({base, 7'h00} + 12'(4 * i), 1, {24'h0, s[i]});
   endtask
   task msg(input string b, input logic g);
      int n;
      gate_i <= g;
      u_snd.send(snd, b);
      n = 0;
      while (msg_done_o !== 1'b1 && n < 20) begin
         @(posedge clk_sys_i);
         n++;
      end
      `CHK("done", 1'b1, msg_done_o)
   endtask
   task clr;
      clear_i <= 1;
      repeat (2) @(posedge clk_sys_i);
      clear_i <= 0;
   endtask
   task t_bit;
      msg("OFF.ON", 1); `CHK("offdis", 1'b1, bit_o)
      clr;
      xfer(`SMC_REG_CTRL, 1, 32'h4);
      msg("ON", 1); `CHK("on", 1'b1, bit_o)
      msg(" OFF . ON", 1); `CHK("first", 1'b0, bit_o)
      msg("X.ON", 0); `CHK("gate", 1'b0, bit_o)
      msg("ONX.ONE", 1); `CHK("exact", 1'b0, bit_o)
      msg("A.B.C.D.E.F.G.H.I.J.ON", 1); `CHK("ten", 1'b0, bit_o)
      msg("Q . ON", 1); `CHK("blank", 1'b1, bit_o)
      msg("OFF.", 1); `CHK("off", 1'b0, bit_o)
      xfer(`SMC_REG_LEN, 1, 32'h03030202);
      txt(`SMC_OFF_BASE, "ON");
      msg("ON", 1); `CHK("same", 1'b1, bit_o)
      clr; `CHK("clear", 1'b0, bit_o)
      txt(`SMC_OFF_BASE, "OFF");
      xfer(`SMC_REG_LEN, 1, 32'h03030302);
   endtask
   task t_pwd;
      xfer(`SMC_REG_PWD, 1, 32'h1443);
      xfer(`SMC_REG_CTRL, 1, 32'h6);
      msg("1442.ON", 1); `CHK("badcode", 1'b0, bit_o)
      msg("1443.ON", 1); `CHK("code", 1'b1, bit_o)
   endtask
   task t_snd;
      xfer(`SMC_REG_CTRL, 1, 32'hC);
      snd = "12";
      msg("OFF", 1); `CHK("short", 1'b1, bit_o)
      snd = "1234";
      msg("OFF", 1); `CHK("star", 1'b0, bit_o)
      snd = "123";
   endtask
   task t_word;
      string s;
      xfer(`SMC_REG_CTRL, 1, 32'h1);
      msg("SET=-32768", 1); `CHK("min", 16'h8000, word_o)
      msg("SET = 1233 .", 1); `CHK("val", 16'h04D1, word_o)
      msg("SET=x1", 1); `CHK("badch", 16'h04D1, word_o)
      msg("SET=32768", 1); `CHK("over", 16'h04D1, word_o)
      msg("SET=+7.SET=9", 1); `CHK("plus", 16'h0007, word_o)
      clr; `CHK("wclr", 16'h0000, word_o)
      s = "SET=5";
      repeat (155) s = {s, " "};
      msg({s, " "}, 1); `CHK("long", 16'h0000, word_o)
      msg(s, 1); `CHK("limit", 16'h0005, word_o)
   endtask
   task t_regs;
      xfer(`SMC_REG_CTRL, 0, 0); `CHK("ctrl", 32'h1, rd)
      xfer(12'h0F0, 0, 0); `CHK("unmapped", 32'h0, rd)
      xfer(12'h104, 1, 32'h7F);
      xfer(12'h104, 0, 0); `CHK("charset", 32'h4E, rd)
      xfer(`SMC_REG_STAT, 0, 0); `CHK("stat", 32'h0005_0002, rd)
      `CHK("resp", 1'b0, hresp_o)
   endtask
   task test_done;
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_sys_i);
      nrst_i <= 1;
      @(posedge clk_sys_i);
      txt(`SMC_ON_BASE, "ON");
      txt(`SMC_OFF_BASE, "OFF");
      txt(`SMC_VAL_BASE, "SET");
      txt(`SMC_SND_BASE, "12*");
      xfer(`SMC_REG_LEN, 1, 32'h03030302);
      t_bit;
      t_pwd;
      t_snd;
      t_word;
      t_regs;
      test_done;
   end
   // Whole run needs under a thousand cycles; ample margin before giving up
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      num_errors++;
      test_done;
   end
endmodule
